// File: shared/uart_regs.svh
// Register addresses, reset values and timing counts of the serial port
`ifndef UART_REGS_SVH
`define UART_REGS_SVH

`define UART_CTRL_ADDR   8'h98
`define UART_BUF_ADDR    8'h99
`define UART_CTRL_RESET  8'h00
`define UART_BUF_RESET   8'h00
`define UART_M0_DIV      6
`define UART_M0_RISE     3
`define UART_OVS         16
`define UART_DATA_BITS   8

`endif

// File: shared/uart_pkg.sv
// Types shared by the serial port modules
package uart_pkg;

  typedef enum logic [1:0] {
    MODE_SHIFT   = 2'b00,
    MODE_8BIT    = 2'b01,
    MODE_9BIT_FX = 2'b10,
    MODE_9BIT_TV = 2'b11
  } mode_t;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiproc_filter_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } ctrl_t;

  typedef struct packed {
    logic samp;
    logic m0_fall;
    logic m0_rise;
    logic m0_level;
  } baud_ticks_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ARM  = 2'b01,
    TX_SEND = 2'b11,
    TX_LAST = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } rx_state_t;

endpackage : uart_pkg

// File: design/uart_baud_gen.sv
// Bit rate tick generator for the serial port
`timescale 1ns/1ps
`include "uart_regs.svh"

module uart_baud_gen #(
  parameter int unsigned M0_DIV = `UART_M0_DIV
) (
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  input  wire logic [1:0]           mode_in,
  input  wire logic                 baud_doubler_in,
  input  wire logic                 timer1_ovf_in,
  output uart_pkg::baud_ticks_t     ticks_out
);

  logic [2:0] m0_cnt_r;
  logic       half_clk_r;
  logic       half_ovf_r;
  logic       samp_nxt;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      m0_cnt_r <= 3'h0;
    end else if (m0_cnt_r == 3'(M0_DIV - 1)) begin
      m0_cnt_r <= 3'h0;
    end else begin
      m0_cnt_r <= m0_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      half_clk_r <= 1'b0;
      half_ovf_r <= 1'b0;
    end else begin
      half_clk_r <= ~half_clk_r;
      if (timer1_ovf_in) begin
        half_ovf_r <= ~half_ovf_r;
      end
    end
  end

  // Sample tick runs 16 times the bit rate
  always_comb begin
    samp_nxt = 1'b0;
    case (mode_in)
      2'b10:   samp_nxt = baud_doubler_in | half_clk_r;
      2'b01,
      2'b11:   samp_nxt = timer1_ovf_in & (baud_doubler_in | half_ovf_r);
      default: samp_nxt = 1'b0;
    endcase
  end

  // Shift clock low for the first half of each six clock slot
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ticks_out <= '0;
    end else begin
      ticks_out.samp     <= samp_nxt;
      ticks_out.m0_fall  <= (m0_cnt_r == 3'h0);
      ticks_out.m0_rise  <= (m0_cnt_r == 3'(`UART_M0_RISE));
      ticks_out.m0_level <= (m0_cnt_r >= 3'(`UART_M0_RISE));
    end
  end

endmodule : uart_baud_gen

// File: design/enhanced_uart_serial_port.sv
// Serial port with shift register mode, 8 and 9 bit asynchronous modes
`timescale 1ns/1ps
`include "uart_regs.svh"

module enhanced_uart_serial_port #(
  parameter int unsigned OVS       = `UART_OVS,
  parameter int unsigned DATA_BITS = `UART_DATA_BITS
) (
  input  wire logic       clock_in,
  input  wire logic       rstn_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic       sfr_wr_in,
  input  wire logic       sfr_rd_in,
  input  wire logic [7:0] sfr_wdata_in,
  output logic      [7:0] sfr_rdata_out,
  input  wire logic       bit7_view_select_in,
  input  wire logic       baud_doubler_in,
  input  wire logic       timer1_ovf_in,
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe_n_out,
  output logic            txd_out,
  output logic            tx_done_flag_out,
  output logic            rx_done_flag_out
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  // Bit index whose end opens the stop phase, or ends a shift mode byte
  function automatic logic tx_at_last(input logic m0, input logic ninth, input logic [3:0] idx);
    if (m0) begin
      tx_at_last = (idx == 4'(DATA_BITS - 1));
    end else if (ninth) begin
      tx_at_last = (idx == 4'(DATA_BITS + 1));
    end else begin
      tx_at_last = (idx == 4'(DATA_BITS));
    end
  endfunction : tx_at_last

  uart_pkg::ctrl_t       ctrl_r;
  logic                  fe_r;
  logic [7:0]            rx_hold_r;
  uart_pkg::tx_state_t   tx_state_r;
  uart_pkg::rx_state_t   rx_state_r;
  logic [10:0]           tx_sh_r;
  logic [3:0]            tx_bit_r;
  logic [3:0]            tx_tick_r;
  logic [8:0]            rx_sh_r;
  logic [3:0]            rx_bit_r;
  logic [3:0]            rx_tick_r;
  logic                  rx_prev_r;
  uart_pkg::baud_ticks_t ticks;
  uart_pkg::mode_t       mode;
  logic                  is_m0;
  logic                  nine;
  logic                  wr_ctrl;
  logic                  wr_buf;
  logic                  tx_bit_end;
  logic                  rx_mid;
  logic                  rx_bit_end;
  logic                  ti_set;
  logic                  ri_set;
  logic                  fe_set;
  logic                  rb8_load;
  logic                  rb8_val;
  logic [7:0]            rx_data;
  logic                  stop_ok;
  logic                  accept;
  logic                  m0_tx_clk;
  logic                  m0_rx_clk;

  assign mode    = uart_pkg::mode_t'({ctrl_r.mode_select_high, ctrl_r.mode_select_low});
  assign is_m0   = (mode == uart_pkg::MODE_SHIFT);
  assign nine    = ctrl_r.mode_select_high;
  assign wr_ctrl = sfr_wr_in & hit(sfr_addr_in, `UART_CTRL_ADDR);
  assign wr_buf  = sfr_wr_in & hit(sfr_addr_in, `UART_BUF_ADDR);

  uart_baud_gen #(
    .M0_DIV (`UART_M0_DIV)
  ) u_baud (
    .clock_in        (clock_in),
    .rstn_in         (rstn_in),
    .mode_in         ({ctrl_r.mode_select_high, ctrl_r.mode_select_low}),
    .baud_doubler_in (baud_doubler_in),
    .timer1_ovf_in   (timer1_ovf_in),
    .ticks_out       (ticks)
  );

  // Transmitter
  assign tx_bit_end = is_m0 ? ticks.m0_fall
                            : (ticks.samp && tx_tick_r == 4'(OVS - 1));

  // A write while busy restarts the frame rather than queueing it
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state_r <= uart_pkg::TX_IDLE;
      tx_sh_r    <= '1;
      tx_bit_r   <= 4'h0;
      tx_tick_r  <= 4'h0;
    end else if (wr_buf) begin
      tx_bit_r  <= 4'h0;
      tx_tick_r <= 4'h0;
      if (is_m0) begin
        tx_sh_r    <= {3'h7, sfr_wdata_in};
        tx_state_r <= uart_pkg::TX_ARM;
      end else begin
        tx_sh_r    <= nine ? {1'b1, ctrl_r.tx_ninth_bit, sfr_wdata_in, 1'b0}
                           : {2'h3, sfr_wdata_in, 1'b0};
        tx_state_r <= uart_pkg::TX_SEND;
      end
    end else begin
      if (ticks.samp) begin
        tx_tick_r <= tx_tick_r + 4'h1;
      end
      case (tx_state_r)
        uart_pkg::TX_ARM: begin
          if (ticks.m0_fall) begin
            tx_state_r <= uart_pkg::TX_SEND;
          end
        end
        uart_pkg::TX_SEND: begin
          if (tx_bit_end) begin
            tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_at_last(is_m0, nine, tx_bit_r)) begin
              if (is_m0) begin
                tx_state_r <= uart_pkg::TX_IDLE;
              end else begin
                tx_state_r <= uart_pkg::TX_LAST;
              end
            end
          end
        end
        uart_pkg::TX_LAST: begin
          if (tx_bit_end) begin
            tx_state_r <= uart_pkg::TX_IDLE;
          end
        end
        default: begin
          tx_state_r <= uart_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // Flag at end of mode 0 byte, else as the stop bit begins
  assign ti_set = !wr_buf && tx_state_r == uart_pkg::TX_SEND && tx_bit_end
                  && tx_at_last(is_m0, nine, tx_bit_r);

  // Receiver
  assign rx_mid     = ticks.samp && rx_tick_r == 4'(OVS / 2 - 1);
  assign rx_bit_end = is_m0 ? ticks.m0_rise : rx_mid;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_prev_r <= 1'b1;
    end else if (ticks.samp) begin
      rx_prev_r <= rxd_in;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_state_r <= uart_pkg::RX_IDLE;
      rx_sh_r    <= 9'h000;
      rx_bit_r   <= 4'h0;
      rx_tick_r  <= 4'h0;
    end else begin
      if (ticks.samp) begin
        rx_tick_r <= rx_tick_r + 4'h1;
      end
      case (rx_state_r)
        uart_pkg::RX_IDLE: begin
          rx_bit_r <= 4'h0;
          if (is_m0 && ctrl_r.rx_enable && !ctrl_r.rx_done_flag
              && tx_state_r == uart_pkg::TX_IDLE) begin
            rx_state_r <= uart_pkg::RX_START;
          end else if (!is_m0 && ctrl_r.rx_enable && ticks.samp
                       && rx_prev_r && !rxd_in) begin
            rx_state_r <= uart_pkg::RX_START;
            rx_tick_r  <= 4'h1;
          end
        end
        uart_pkg::RX_START: begin
          if (is_m0) begin
            if (ticks.m0_fall) begin
              rx_state_r <= uart_pkg::RX_DATA;
            end
          end else if (rx_mid) begin
            // A glitch shorter than half a bit is not a start bit
            rx_state_r <= rxd_in ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
          end
        end
        uart_pkg::RX_DATA: begin
          if (rx_bit_end) begin
            rx_sh_r  <= {rxd_in, rx_sh_r[8:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == ((nine && !is_m0) ? 4'(DATA_BITS) : 4'(DATA_BITS - 1))) begin
              rx_state_r <= uart_pkg::RX_STOP;
            end
          end
        end
        uart_pkg::RX_STOP: begin
          if (is_m0 ? ticks.m0_fall : rx_mid) begin
            rx_state_r <= uart_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= uart_pkg::RX_IDLE;
        end
      endcase
    end
  end

  assign rx_data  = (nine && !is_m0) ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign stop_ok  = rxd_in;
  assign rb8_val  = nine ? rx_sh_r[8] : stop_ok;
  assign accept   = is_m0 || !ctrl_r.multiproc_filter_enable || rb8_val;
  assign ri_set   = rx_state_r == uart_pkg::RX_STOP
                    && (is_m0 ? ticks.m0_fall : rx_mid) && accept;
  assign rb8_load = ri_set && !is_m0;
  assign fe_set   = rx_state_r == uart_pkg::RX_STOP && !is_m0 && rx_mid
                    && !stop_ok;

  // Holding register is rewritten even if unread
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_hold_r <= `UART_BUF_RESET;
    end else if (ri_set) begin
      rx_hold_r <= rx_data;
    end
  end

  // Hardware sets follow software writes so a set in the clearing cycle wins
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= uart_pkg::ctrl_t'(`UART_CTRL_RESET);
      fe_r   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= uart_pkg::ctrl_t'(sfr_wdata_in);
        if (bit7_view_select_in) begin
          ctrl_r.mode_select_high <= ctrl_r.mode_select_high;
          fe_r                    <= sfr_wdata_in[7];
        end
      end
      if (fe_set) begin
        fe_r <= 1'b1;
      end
      if (rb8_load) begin
        ctrl_r.rx_ninth_bit <= rb8_val;
      end
      if (ti_set) begin
        ctrl_r.tx_done_flag <= 1'b1;
      end
      if (ri_set) begin
        ctrl_r.rx_done_flag <= 1'b1;
      end
    end
  end

  // Register read port
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (sfr_rd_in) begin
      if (hit(sfr_addr_in, `UART_BUF_ADDR)) begin
        sfr_rdata_out <= rx_hold_r;
      end else if (hit(sfr_addr_in, `UART_CTRL_ADDR)) begin
        sfr_rdata_out <= {bit7_view_select_in ? fe_r : ctrl_r.mode_select_high,
                          ctrl_r[6:0]};
      end else begin
        sfr_rdata_out <= 8'h00;
      end
    end
  end

  // Shift clock gates open on the slot fall that starts a byte; the transmit gate shuts on the
  // fall after the last bit, the receive gate after the last bit's rise, so neither end of a byte shows a short pulse
  assign m0_tx_clk = (tx_state_r == uart_pkg::TX_ARM && ticks.m0_fall)
                     || (tx_state_r == uart_pkg::TX_SEND
                         && !(ticks.m0_fall && tx_at_last(is_m0, nine, tx_bit_r)));
  assign m0_rx_clk = (rx_state_r == uart_pkg::RX_START && ticks.m0_fall)
                     || rx_state_r == uart_pkg::RX_DATA;

  // Pins; mode 0 drives the clock on the transmit pin for either direction
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      txd_out      <= 1'b1;
      rxd_out      <= 1'b1;
      rxd_oe_n_out <= 1'b1;
    end else if (is_m0) begin
      txd_out      <= (m0_tx_clk || m0_rx_clk) ? ticks.m0_level : 1'b1;
      rxd_out      <= tx_sh_r[0];
      rxd_oe_n_out <= (tx_state_r != uart_pkg::TX_SEND);
    end else begin
      txd_out      <= (tx_state_r == uart_pkg::TX_IDLE) ? 1'b1 : tx_sh_r[0];
      rxd_out      <= 1'b1;
      rxd_oe_n_out <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_done_flag_out <= 1'b0;
      rx_done_flag_out <= 1'b0;
    end else begin
      tx_done_flag_out <= ctrl_r.tx_done_flag;
      rx_done_flag_out <= ctrl_r.rx_done_flag;
    end
  end

endmodule : enhanced_uart_serial_port

// File: testbench/uart_sva.sv
// Assertion checker for the serial port pins and register strobes
`timescale 1ns/1ps
`include "uart_regs.svh"
module uart_sva (
  input wire logic       clock_in,
  input wire logic       rstn_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic       sfr_wr_in,
  input wire logic       sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic       bit7_view_select_in,
  input wire logic       baud_doubler_in,
  input wire logic       rxd_oe_n_out,
  input wire logic       txd_out,
  input wire logic       rx_done_flag_out
);
  logic [1:0] mode_r;
  logic       ren_r;
  wire        ctl_wr = sfr_wr_in && sfr_addr_in == `UART_CTRL_ADDR;
  wire        buf_wr = sfr_wr_in && sfr_addr_in == `UART_BUF_ADDR;
  wire        m2f    = mode_r == 2'h2 && baud_doubler_in;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rstn_in);

  // Bit 7 only lands in the mode while it is shown as the mode bit
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_r <= 2'h0;
      ren_r  <= 1'h0;
    end else if (ctl_wr) begin
      mode_r[0] <= sfr_wdata_in[6];
      ren_r     <= sfr_wdata_in[4];
      if (!bit7_view_select_in) begin
        mode_r[1] <= sfr_wdata_in[7];
      end
    end
  end

  unmapped_read_a: assert property (
    sfr_rd_in && !ctl_wr && sfr_addr_in != `UART_CTRL_ADDR && sfr_addr_in != `UART_BUF_ADDR
    |=> sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
  start_delay_a: assert property (buf_wr && mode_r != 2'h0 |-> ##2 !txd_out)
    else $error("start bit late");
  start_width_a: assert property ($fell(txd_out) && m2f |-> !txd_out[*8] ##8 !txd_out)
    else $error("low bit not sixteen clocks");
  mark_width_a: assert property ($rose(txd_out) && m2f |-> txd_out[*8])
    else $error("high bit too short");
  shift_low_a: assert property ($fell(txd_out) && mode_r == 2'h0 |-> !txd_out[*3] ##1 txd_out)
    else $error("shift clock low phase wrong");
  shift_high_a: assert property ($rose(txd_out) && mode_r == 2'h0 |-> txd_out[*3])
    else $error("shift clock high phase short");
  drive_mode_a: assert property (!rxd_oe_n_out |-> mode_r == 2'h0)
    else $error("data pin driven outside shift mode");
  rx_gate_a: assert property ($rose(rx_done_flag_out) |-> ren_r)
    else $error("receive flag without enable");
endmodule : uart_sva

bind enhanced_uart_serial_port uart_sva u_sva (
  .clock_in, .rstn_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out,
  .bit7_view_select_in, .baud_doubler_in, .rxd_oe_n_out, .txd_out, .rx_done_flag_out
);

// File: testbench/remote_serial_dev.sv
// Behavioural remote serial device on the receive and transmit pins
`timescale 1ns/1ps
module remote_serial_dev (
  input  wire logic clock_in,
  input  wire logic txd_in,
  input  wire logic data_in,
  output logic      line_out
);
  initial line_out = 1'h1;

  // Frame out LSB first, line back at mark level afterwards
  task automatic send(input logic [10:0] f, input int n, input int bc);
    for (int i = 0; i < n; i++) begin
      line_out = f[i];
      repeat (bc) @(negedge clock_in);
    end
    line_out = 1'h1;
    @(negedge clock_in);
  endtask : send

  task automatic catch_async(output logic [10:0] f, input int n, input int bc);
    f = 11'h7ff;
    @(negedge txd_in);
    repeat (bc / 2) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      f[i] = txd_in;
      repeat (bc) @(posedge clock_in);
    end
  endtask : catch_async

  task automatic catch_shift(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_in);
      d[i] = data_in;
    end
  endtask : catch_shift

  // Data changes only at the clock fall; released line shows the inverse
  task automatic feed_shift(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      line_out = d[i];
      @(posedge txd_in);
      if (i < 7) @(negedge txd_in);
    end
    repeat (3) @(posedge clock_in);
    line_out = ~d[7];
  endtask : feed_shift
endmodule : remote_serial_dev

// File: testbench/tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`include "uart_regs.svh"
module tb;
  logic        clk;
  logic        rstn;
  logic [7:0]  addr;
  logic        wr;
  logic        rd;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        view;
  logic        dbl;
  logic        ovf;
  logic        line;
  logic        rxd_o;
  logic        oe_n;
  logic        txd;
  logic        txf;
  logic        rxf;
  logic        rxd_pin;
  logic [10:0] f;
  logic [7:0]  d;
  int          mismatches;
  int          n_checks;

  assign rxd_pin = oe_n ? line : rxd_o;

  enhanced_uart_serial_port u_dut (
    .clock_in(clk), .rstn_in(rstn), .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .bit7_view_select_in(view),
    .baud_doubler_in(dbl), .timer1_ovf_in(ovf), .rxd_in(rxd_pin), .rxd_out(rxd_o),
    .rxd_oe_n_out(oe_n), .txd_out(txd), .tx_done_flag_out(txf), .rx_done_flag_out(rxf)
  );
  remote_serial_dev u_far (.clock_in(clk), .txd_in(txd), .data_in(rxd_o), .line_out(line));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Overflow pulse every second clock stands in for the timer
  always @(negedge clk) ovf <= ~ovf;

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'h1;
    @(negedge clk);
    wr = 1'h0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(negedge clk);
    addr = a;
    rd = 1'h1;
    @(negedge clk);
    rd = 1'h0;
    v = rdata;
  endtask : rreg

  task automatic wait_flag(input bit tx);
    for (int k = 0; k < 2000 && (tx ? txf : rxf) !== 1'h1; k++) @(negedge clk);
  endtask : wait_flag

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run

  // Whole run is near 40 us; five times that means a hang
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end

  initial begin
    rstn = 1'h0;
    addr = 8'h00;
    wr = 1'h0;
    rd = 1'h0;
    wdata = 8'h00;
    view = 1'h0;
    dbl = 1'h1;
    ovf = 1'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (3) @(negedge clk);
    rstn = 1'h1;
    rreg(`UART_CTRL_ADDR, d);
    chk(d, `UART_CTRL_RESET);
    rreg(8'h9a, d);
    chk(d, 8'h00);
    chk(txd, 1'h1);
    $display("test reset done");
    wreg(`UART_CTRL_ADDR, 8'h88);
    fork
      u_far.catch_async(f, 11, 16);
      wreg(`UART_BUF_ADDR, 8'ha5);
    join
    chk(f, {2'h3, 8'ha5, 1'h0});
    chk(txf, 1'h1);
    wreg(`UART_CTRL_ADDR, 8'h88);
    repeat (2) @(negedge clk);
    chk(txf, 1'h0);
    dbl = 1'h0;
    wreg(`UART_CTRL_ADDR, 8'h80);
    fork
      u_far.catch_async(f, 11, 32);
      wreg(`UART_BUF_ADDR, 8'h5a);
    join
    chk(f, {2'h2, 8'h5a, 1'h0});
    $display("test mode2_tx done");
    wreg(`UART_CTRL_ADDR, 8'h50);
    fork
      u_far.catch_async(f, 10, 64);
      wreg(`UART_BUF_ADDR, 8'hc3);
      u_far.send({2'h3, 8'h3c, 1'h0}, 10, 64);
    join
    chk(f, {2'h3, 8'hc3, 1'h0});
    chk(rxf, 1'h1);
    rreg(`UART_BUF_ADDR, d);
    chk(d, 8'h3c);
    rreg(`UART_CTRL_ADDR, d);
    chk(d, 8'h57);
    wreg(`UART_CTRL_ADDR, 8'h50);
    u_far.send({2'h3, 8'h11, 1'h0}, 10, 64);
    u_far.send({2'h3, 8'h22, 1'h0}, 10, 64);
    rreg(`UART_BUF_ADDR, d);
    chk(d, 8'h22);
    $display("test mode1_duplex done");
    dbl = 1'h1;
    wreg(`UART_CTRL_ADDR, 8'hf0);
    u_far.send({2'h2, 8'h77, 1'h0}, 11, 32);
    chk(rxf, 1'h0);
    rreg(`UART_BUF_ADDR, d);
    chk(d, 8'h22);
    u_far.send({2'h3, 8'h99, 1'h0}, 11, 32);
    chk(rxf, 1'h1);
    rreg(`UART_CTRL_ADDR, d);
    chk(d, 8'hf5);
    rreg(`UART_BUF_ADDR, d);
    chk(d, 8'h99);
    $display("test mode3_filter done");
    wreg(`UART_CTRL_ADDR, 8'h90);
    u_far.send({2'h0, 8'h12, 1'h0}, 11, 16);
    view = 1'h1;
    rreg(`UART_CTRL_ADDR, d);
    chk(d, 8'h91);
    u_far.send({2'h3, 8'h34, 1'h0}, 11, 16);
    rreg(`UART_CTRL_ADDR, d);
    chk(d, 8'h95);
    wreg(`UART_CTRL_ADDR, 8'h10);
    rreg(`UART_CTRL_ADDR, d);
    chk(d, 8'h10);
    view = 1'h0;
    rreg(`UART_CTRL_ADDR, d);
    chk(d, 8'h90);
    wreg(`UART_CTRL_ADDR, 8'h80);
    u_far.send({2'h3, 8'h56, 1'h0}, 11, 16);
    chk(rxf, 1'h0);
    rreg(`UART_BUF_ADDR, d);
    chk(d, 8'h34);
    $display("test framing done");
    wreg(`UART_CTRL_ADDR, 8'h00);
    fork
      u_far.catch_shift(d);
      wreg(`UART_BUF_ADDR, 8'h96);
    join
    chk(d, 8'h96);
    wait_flag(1'h1);
    chk(txf, 1'h1);
    fork
      u_far.feed_shift(8'h6b);
      wreg(`UART_CTRL_ADDR, 8'h10);
    join
    wait_flag(1'h0);
    chk(rxf, 1'h1);
    rreg(`UART_BUF_ADDR, d);
    chk(d, 8'h6b);
    $display("test mode0 done");
    complete_run();
  end
endmodule : tb
